// ### common/pwmhz_consts.svh
// register indices, field positions, reset values and timing counts of the
// pwm high-impedance shutdown block; assumes nothing but a preprocessor
`ifndef PWMHZ_CONSTS_SVH
`define PWMHZ_CONSTS_SVH

// printed offsets are register indices; byte address is four times the index
`define PWMHZ_IDX_TRIG_EN 16'hff6e
`define PWMHZ_IDX_SRC_SEL 16'hff6f
`define PWMHZ_IDX_CTRL 16'hff78
`define PWMHZ_IDX_IRQ_STAT 16'hff80
`define PWMHZ_IDX_IRQ_MASK 16'hff81
`define PWMHZ_IDX_W 16

`define PWMHZ_RST_TRIG_EN 8'h00
`define PWMHZ_RST_SRC_SEL 8'h00
`define PWMHZ_RST_CTRL 8'h00
`define PWMHZ_RST_IRQ 3'h0

`define PWMHZ_MASK_TRIG_EN 8'h80
`define PWMHZ_MASK_SRC_SEL 8'hcf

`define PWMHZ_GATE_BIT 7
`define PWMHZ_SRC_HI 7
`define PWMHZ_SRC_LO 6
`define PWMHZ_PIN_HI 3
`define PWMHZ_OPEN_BIT 7
`define PWMHZ_POLICY_BIT 6
`define PWMHZ_FALL_BIT 5
`define PWMHZ_RISE_BIT 4
`define PWMHZ_SOFT_BIT 3
`define PWMHZ_REL_BIT 2
`define PWMHZ_FLAG_BIT 0

`define PWMHZ_EVT_HW 0
`define PWMHZ_EVT_SW 1
`define PWMHZ_EVT_REL 2
`define PWMHZ_EVT_W 3

`define PWMHZ_SYNC_STAGES 2

`endif

// ### common/pwmhz_pkg.sv
// types shared by the pwm high-impedance shutdown block
// assumes the constants header is compiled alongside
package pwmhz_pkg;

   typedef enum logic [1:0] {
      PWMHZ_SRC_EXT = 2'h0,
      PWMHZ_SRC_CMP0 = 2'h1,
      PWMHZ_SRC_CMP1 = 2'h2,
      PWMHZ_SRC_CMP2 = 2'h3
   } pwmhz_src_e;

   typedef enum logic [1:0] {
      PWMHZ_EDGE_NONE = 2'h0,
      PWMHZ_EDGE_RISE = 2'h1,
      PWMHZ_EDGE_FALL = 2'h2,
      PWMHZ_EDGE_BAD = 2'h3
   } pwmhz_edge_e;

   typedef enum logic [1:0] {
      PWMHZ_ST_DRIVE = 2'b01,
      PWMHZ_ST_HIZ = 2'b10
   } pwmhz_state_e;

endpackage : pwmhz_pkg

// ### design/pwmhz_edge.sv
// valid-edge detector and active-level decode for the selected trigger
// assumes i_level is already synchronous to i_clk
`timescale 1ns/1ps
`include "pwmhz_consts.svh"
module pwmhz_edge (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_level,
   input wire logic i_gate,
   input wire logic i_enable,
   input wire logic [1:0] i_edge_sel,
   output logic o_edge,
   output logic o_active
);
   logic prev_r;
   logic prev_nxt;

   // prev tracks the level even while disabled, so a level already active
   // at enable time shows no edge
   always_comb begin
      prev_nxt = i_level;
      o_edge = 1'b0;
      o_active = 1'b0;
      case (pwmhz_pkg::pwmhz_edge_e'(i_edge_sel))
         pwmhz_pkg::PWMHZ_EDGE_RISE: begin
            o_edge = i_level & ~prev_r;
            o_active = i_level;
         end
         pwmhz_pkg::PWMHZ_EDGE_FALL: begin
            o_edge = ~i_level & prev_r;
            o_active = ~i_level;
         end
         default: begin
            o_edge = 1'b0;
            o_active = 1'b0;
         end
      endcase
      o_edge = o_edge & i_gate & i_enable;
      o_active = o_active & i_gate;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   edge_needs_change_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_edge |-> (i_level != prev_r))
      else $error("edge reported without a level change");
endmodule : pwmhz_edge

// ### design/pwmhz_sync.sv
// two-flop level synchroniser for the trigger inputs
// assumes inputs may change at any time relative to i_clk
`timescale 1ns/1ps
`include "pwmhz_consts.svh"
module pwmhz_sync #(
   parameter int WIDTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   if (WIDTH < 1) begin : g_bad_width
      $error("pwmhz_sync: WIDTH must be at least 1");
   end

   // meta_r feeds sync_r only
   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule : pwmhz_sync

// ### design/pwmhz_top.sv
// pwm output high-impedance shutdown controller with apb register access
// assumes apb master clocked by I_CLK; trigger inputs arrive asynchronously
// Operation
// - gate bit blocks or passes the trigger
// - all three registers reset to zero
// - source field selects ext input or comparator
// - pin target bits choose which pins float
// - enable bit turns the shutdown function on
// - policy bit blocks release while trigger active
// - edge field: none, rising, falling, prohibited
// - only edges after enabling cause shutdown
// - soft trigger write floats pins, sets flag
// - release write drives pins, clears flag
// - flag read-only, set and cleared by hardware
// - soft trigger ignored on coinciding hardware edge
// - commands ignored while function disabled
// - command bits read back as zero
// - policy one: release lost on coinciding edge
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "pwmhz_consts.svh"
module pwmhz_top #(
   parameter int ADDR_W = 18
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_EXT_IRQ_INPUT,
   input wire logic I_CMP0_OUT,
   input wire logic I_CMP1_OUT,
   input wire logic I_CMP2_OUT,
   input wire logic I_TIMER_OUT_A0,
   input wire logic I_TIMER_OUT_A1,
   input wire logic I_TIMER_OUT_B0,
   input wire logic I_TIMER_OUT_B1,
   output logic O_TIMER_OUT_A0,
   output logic O_TIMER_OUT_A1,
   output logic O_TIMER_OUT_B0,
   output logic O_TIMER_OUT_B1,
   output logic O_TIMER_OUT_A0_OE,
   output logic O_TIMER_OUT_A1_OE,
   output logic O_TIMER_OUT_B0_OE,
   output logic O_TIMER_OUT_B1_OE,
   output logic O_IRQ
);
   if (ADDR_W < `PWMHZ_IDX_W + 2) begin : g_bad_addr
      $error("pwmhz_top: ADDR_W too narrow for the register map");
   end

   localparam int NREG = 5;
   localparam int R_TEN = 0;
   localparam int R_SEL = 1;
   localparam int R_CTL = 2;
   localparam int R_IST = 3;
   localparam int R_IMK = 4;

   function automatic logic [NREG-1:0] reg_dec(input logic [ADDR_W-1:0] a);
      logic [NREG-1:0] h;
      h = '0;
      h[R_TEN] = (a == ADDR_W'({`PWMHZ_IDX_TRIG_EN, 2'b00}));
      h[R_SEL] = (a == ADDR_W'({`PWMHZ_IDX_SRC_SEL, 2'b00}));
      h[R_CTL] = (a == ADDR_W'({`PWMHZ_IDX_CTRL, 2'b00}));
      h[R_IST] = (a == ADDR_W'({`PWMHZ_IDX_IRQ_STAT, 2'b00}));
      h[R_IMK] = (a == ADDR_W'({`PWMHZ_IDX_IRQ_MASK, 2'b00}));
      return h;
   endfunction : reg_dec

   // apb slave state
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic [NREG-1:0] hit;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] wd;

   // configuration
   logic [7:0] trig_en_r;
   logic [7:0] trig_en_nxt;
   logic [7:0] src_sel_r;
   logic [7:0] src_sel_nxt;
   logic op_en_r;
   logic op_en_nxt;
   logic policy_r;
   logic policy_nxt;
   logic [1:0] edge_sel_r;
   logic [1:0] edge_sel_nxt;

   // shutdown state
   pwmhz_pkg::pwmhz_state_e state_r;
   pwmhz_pkg::pwmhz_state_e state_nxt;
   logic flag_r;
   logic flag_nxt;
   logic wr_ctl;
   logic sw_cmd;
   logic rel_cmd;
   logic [`PWMHZ_EVT_W-1:0] evt;

   // interrupt
   logic [`PWMHZ_EVT_W-1:0] ist_r;
   logic [`PWMHZ_EVT_W-1:0] ist_nxt;
   logic [`PWMHZ_EVT_W-1:0] imk_r;
   logic [`PWMHZ_EVT_W-1:0] imk_nxt;
   logic irq_r;
   logic irq_nxt;

   // pins and trigger path
   logic [3:0] pin_in;
   logic [3:0] pin_out_r;
   logic [3:0] pin_out_nxt;
   logic [3:0] pin_oe_r;
   logic [3:0] pin_oe_nxt;
   logic [3:0] trig_sync;
   logic trig_level;
   logic hw_edge;
   logic trig_active;

   assign hit = reg_dec(I_PADDR);
   assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & pready_r;
   assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE & pready_r;
   assign wd = I_PWDATA[7:0];

   // read data is captured in the setup cycle and stands through access
   always_comb begin
      pready_nxt = I_PSEL & ~I_PENABLE;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      if (I_PSEL && !I_PENABLE) begin
         pslverr_nxt = ~|hit;
         prdata_nxt = 32'h0000_0000;
         if (!I_PWRITE) begin
            case (1'b1)
               hit[R_TEN]: prdata_nxt[7:0] = trig_en_r;
               hit[R_SEL]: prdata_nxt[7:0] = src_sel_r;
               hit[R_CTL]: begin
                  prdata_nxt[`PWMHZ_OPEN_BIT] = op_en_r;
                  prdata_nxt[`PWMHZ_POLICY_BIT] = policy_r;
                  prdata_nxt[`PWMHZ_FALL_BIT] = edge_sel_r[1];
                  prdata_nxt[`PWMHZ_RISE_BIT] = edge_sel_r[0];
                  prdata_nxt[`PWMHZ_SOFT_BIT] = 1'b0;
                  prdata_nxt[`PWMHZ_REL_BIT] = 1'b0;
                  prdata_nxt[`PWMHZ_FLAG_BIT] = flag_r;
               end
               hit[R_IST]: prdata_nxt[`PWMHZ_EVT_W-1:0] = ist_r;
               hit[R_IMK]: prdata_nxt[`PWMHZ_EVT_W-1:0] = imk_r;
               default: prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // policy and edge are taken whenever written; keeping them still while
   // enabled is left to software
   always_comb begin
      trig_en_nxt = trig_en_r;
      src_sel_nxt = src_sel_r;
      op_en_nxt = op_en_r;
      policy_nxt = policy_r;
      edge_sel_nxt = edge_sel_r;
      if (wr_acc && hit[R_TEN]) begin
         trig_en_nxt = wd & `PWMHZ_MASK_TRIG_EN;
      end
      if (wr_acc && hit[R_SEL]) begin
         src_sel_nxt = wd & `PWMHZ_MASK_SRC_SEL;
      end
      if (wr_acc && hit[R_CTL]) begin
         op_en_nxt = wd[`PWMHZ_OPEN_BIT];
         policy_nxt = wd[`PWMHZ_POLICY_BIT];
         edge_sel_nxt = {wd[`PWMHZ_FALL_BIT], wd[`PWMHZ_RISE_BIT]};
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         trig_en_r <= `PWMHZ_RST_TRIG_EN;
         src_sel_r <= `PWMHZ_RST_SRC_SEL;
         op_en_r <= 1'b0;
         policy_r <= 1'b0;
         edge_sel_r <= 2'h0;
      end else begin
         trig_en_r <= trig_en_nxt;
         src_sel_r <= src_sel_nxt;
         op_en_r <= op_en_nxt;
         policy_r <= policy_nxt;
         edge_sel_r <= edge_sel_nxt;
      end
   end

   pwmhz_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_async({I_CMP2_OUT, I_CMP1_OUT, I_CMP0_OUT, I_EXT_IRQ_INPUT}),
      .o_sync(trig_sync)
   );

   // muxing after the synchroniser keeps source changes glitch-free
   always_comb begin
      case (pwmhz_pkg::pwmhz_src_e'(src_sel_r[`PWMHZ_SRC_HI:`PWMHZ_SRC_LO]))
         pwmhz_pkg::PWMHZ_SRC_EXT: trig_level = trig_sync[0];
         pwmhz_pkg::PWMHZ_SRC_CMP0: trig_level = trig_sync[1];
         pwmhz_pkg::PWMHZ_SRC_CMP1: trig_level = trig_sync[2];
         pwmhz_pkg::PWMHZ_SRC_CMP2: trig_level = trig_sync[3];
         default: trig_level = 1'b0;
      endcase
   end

   pwmhz_edge u_edge (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_level(trig_level),
      .i_gate(trig_en_r[`PWMHZ_GATE_BIT]),
      .i_enable(op_en_r),
      .i_edge_sel(edge_sel_r),
      .o_edge(hw_edge),
      .o_active(trig_active)
   );

   // commands need the function already enabled and kept enabled
   assign wr_ctl = wr_acc & hit[R_CTL];
   assign sw_cmd = wr_ctl & wd[`PWMHZ_SOFT_BIT] & wd[`PWMHZ_OPEN_BIT] & op_en_r;
   assign rel_cmd = wr_ctl & wd[`PWMHZ_REL_BIT] & wd[`PWMHZ_OPEN_BIT] & op_en_r;

   // flag is only ever changed here; written flag bit is dropped
   always_comb begin
      state_nxt = state_r;
      evt = '0;
      if (!op_en_nxt) begin
         state_nxt = pwmhz_pkg::PWMHZ_ST_DRIVE;
      end else if (sw_cmd && !hw_edge) begin
         // both commands at once are not expected; the trigger is kept
         state_nxt = pwmhz_pkg::PWMHZ_ST_HIZ;
         evt[`PWMHZ_EVT_SW] = 1'b1;
      end else if (rel_cmd && !(policy_r && (trig_active || hw_edge))) begin
         state_nxt = pwmhz_pkg::PWMHZ_ST_DRIVE;
         evt[`PWMHZ_EVT_REL] = (state_r == pwmhz_pkg::PWMHZ_ST_HIZ);
      end else if (hw_edge) begin
         state_nxt = pwmhz_pkg::PWMHZ_ST_HIZ;
         evt[`PWMHZ_EVT_HW] = 1'b1;
      end
      flag_nxt = (state_nxt == pwmhz_pkg::PWMHZ_ST_HIZ);
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_r <= pwmhz_pkg::PWMHZ_ST_DRIVE;
         flag_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         flag_r <= flag_nxt;
      end
   end

   // a read clears only the bits it returned, so an event landing between
   // setup and access survives; set wins over clear
   always_comb begin
      ist_nxt = ist_r;
      imk_nxt = imk_r;
      if (rd_acc && hit[R_IST]) begin
         ist_nxt = ist_r & ~prdata_r[`PWMHZ_EVT_W-1:0];
      end
      ist_nxt = ist_nxt | evt;
      if (wr_acc && hit[R_IMK]) begin
         imk_nxt = wd[`PWMHZ_EVT_W-1:0];
      end
      irq_nxt = |(ist_nxt & imk_nxt);
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ist_r <= `PWMHZ_RST_IRQ;
         imk_r <= `PWMHZ_RST_IRQ;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         imk_r <= imk_nxt;
         irq_r <= irq_nxt;
      end
   end

   // pin data is retimed one cycle so every output leaves a flip-flop
   assign pin_in = {I_TIMER_OUT_B1, I_TIMER_OUT_B0, I_TIMER_OUT_A1, I_TIMER_OUT_A0};
   always_comb begin
      pin_out_nxt = pin_in;
      pin_oe_nxt = ~({4{flag_nxt}} & src_sel_nxt[`PWMHZ_PIN_HI:0]);
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         pin_out_r <= 4'h0;
         pin_oe_r <= 4'hf;
      end else begin
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign O_PRDATA = prdata_r;
   assign O_PREADY = pready_r;
   assign O_PSLVERR = pslverr_r;
   assign O_IRQ = irq_r;
   assign {O_TIMER_OUT_B1, O_TIMER_OUT_B0, O_TIMER_OUT_A1, O_TIMER_OUT_A0} = pin_out_r;
   assign {O_TIMER_OUT_B1_OE, O_TIMER_OUT_B0_OE, O_TIMER_OUT_A1_OE, O_TIMER_OUT_A0_OE} = pin_oe_r;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   gate_blocks_a: assert property (!trig_en_r[`PWMHZ_GATE_BIT] |-> !hw_edge)
      else $error("edge passed while trigger gate closed");
   reset_zero_a: assert property (!$past(I_RST_N) |->
      (trig_en_r == 8'h00 && src_sel_r == 8'h00 && !op_en_r && !policy_r && !flag_r))
      else $error("registers not zero after reset");
   pin_float_a: assert property (pin_oe_r == ~({4{flag_r}} & src_sel_r[3:0]))
      else $error("pin enables disagree with flag and targets");
   disable_drives_a: assert property (!op_en_r |-> !flag_r && pin_oe_r == 4'hf)
      else $error("pins floating while function disabled");
   policy_hold_a: assert property ((rel_cmd && policy_r && trig_active && flag_r)
      |=> flag_r)
      else $error("release taken while trigger active");
   edge_none_a: assert property ((edge_sel_r == 2'h0 || edge_sel_r == 2'h3) |-> !hw_edge)
      else $error("hardware edge with no valid edge selected");
   no_edge_enable_a: assert property ($rose(op_en_r) && trig_active && $stable(trig_level)
      |-> !hw_edge)
      else $error("standing active level caused shutdown");
   soft_trig_a: assert property ((sw_cmd && !rel_cmd) |=> flag_r ##1 1'b1)
      else $error("soft trigger did not set flag");
   release_a: assert property ((rel_cmd && !sw_cmd && !policy_r) |=> !flag_r)
      else $error("release without policy did not clear flag");
   edge_sets_a: assert property ((hw_edge && !rel_cmd && op_en_nxt) |=> flag_r)
      else $error("valid edge did not set flag");
   disabled_cmd_a: assert property ((wr_ctl && !op_en_r) |=> !flag_r)
      else $error("command acted while disabled");
   cmd_read_zero_a: assert property ($past(I_PSEL) && !$past(I_PENABLE)
      && !$past(I_PWRITE) && $past(hit[R_CTL])
      |-> O_PRDATA[`PWMHZ_SOFT_BIT:`PWMHZ_REL_BIT] == 2'b00)
      else $error("command bits read back nonzero");
   coincide_rel_a: assert property ((rel_cmd && policy_r && hw_edge) |=> flag_r)
      else $error("release won over edge under policy one");
   soft_lost_a: assert property ((sw_cmd && hw_edge) |=> ist_r[`PWMHZ_EVT_HW])
      else $error("coinciding edge not recorded as hardware shutdown");

   hw_shutdown_c: cover property (!flag_r ##1 hw_edge ##1 flag_r);
   sw_shutdown_c: cover property (sw_cmd ##1 flag_r);
   release_c: cover property (flag_r && rel_cmd ##1 !flag_r);
   irq_c: cover property ($rose(O_IRQ));
endmodule : pwmhz_top

// ### tb/pwm_hiz_output_shutdown_test.sv
// self-checking bench for the pwm high-impedance shutdown block
// assumes the far-side model and the design files are compiled before it
`timescale 1ns/1ps
`include "pwmhz_consts.svh"
module pwm_hiz_output_shutdown_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [17:0] paddr = 18'h0_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [3:0] trig = 4'h0;
   logic ext, c0, c1, c2;
   logic [3:0] tin;
   logic [3:0] tout;
   logic [3:0] oe;
   logic [7:0] rd;
   logic slv;
   int error_cnt = 0;
   int checks = 0;
   localparam logic [15:0] EN = `PWMHZ_IDX_TRIG_EN;
   localparam logic [15:0] SRC = `PWMHZ_IDX_SRC_SEL;
   localparam logic [15:0] CTL = `PWMHZ_IDX_CTRL;
   localparam logic [15:0] STA = `PWMHZ_IDX_IRQ_STAT;
   localparam logic [15:0] MSK = `PWMHZ_IDX_IRQ_MASK;

   always #25 clk = ~clk;

   pwmhz_far_model pwmhz_far_model_inst (.i_clk(clk), .i_trig(trig), .o_ext(ext),
      .o_cmp0(c0), .o_cmp1(c1), .o_cmp2(c2), .o_timer(tin));

   pwmhz_top pwmhz_top_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EXT_IRQ_INPUT(ext), .I_CMP0_OUT(c0),
      .I_CMP1_OUT(c1), .I_CMP2_OUT(c2), .I_TIMER_OUT_A0(tin[0]), .I_TIMER_OUT_A1(tin[1]),
      .I_TIMER_OUT_B0(tin[2]), .I_TIMER_OUT_B1(tin[3]), .O_TIMER_OUT_A0(tout[0]),
      .O_TIMER_OUT_A1(tout[1]), .O_TIMER_OUT_B0(tout[2]), .O_TIMER_OUT_B1(tout[3]),
      .O_TIMER_OUT_A0_OE(oe[0]), .O_TIMER_OUT_A1_OE(oe[1]), .O_TIMER_OUT_B0_OE(oe[2]),
      .O_TIMER_OUT_B1_OE(oe[3]), .O_IRQ(irq));

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one apb transfer; leaves an idle edge so the next setup never collides
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         finish_test();
      end
      rd = prdata[7:0];
      slv = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rc(input string name, input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(name, rd, exp);
   endtask : rc

   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle

   task automatic t_reset();
      rc("trig enable", EN, 8'h00);
      rc("source select", SRC, 8'h00);
      rc("control", CTL, 8'h00);
      chk("oe at reset", {4'h0, oe}, 8'h0f);
      apb(1'b0, 16'hff70, 8'h00);
      chk("unmapped err", {7'h00, slv}, 8'h01);
      @(posedge clk);
      #1;
      chk("pin data", {4'h0, tout}, {4'h0, tin - 4'h1});
      @(posedge clk);
   endtask : t_reset

   task automatic t_soft();
      wr(SRC, 8'h05);
      wr(MSK, 8'h02);
      wr(CTL, 8'h08);
      rc("soft while off", CTL, 8'h00);
      wr(CTL, 8'h80);
      wr(CTL, 8'h88);
      rc("soft flag", CTL, 8'h81);
      chk("soft oe", {4'h0, oe}, 8'h0a);
      chk("irq up", {7'h00, irq}, 8'h01);
      rc("irq status", STA, 8'h02);
      chk("irq cleared", {7'h00, irq}, 8'h00);
      wr(CTL, 8'h81);
      rc("flag read only", CTL, 8'h81);
      wr(CTL, 8'h84);
      rc("release", CTL, 8'h80);
      chk("release oe", {4'h0, oe}, 8'h0f);
      chk("release masked", {7'h00, irq}, 8'h00);
      wr(CTL, 8'h88);
      wr(CTL, 8'h00);
      rc("disable clears", CTL, 8'h00);
      chk("disable oe", {4'h0, oe}, 8'h0f);
   endtask : t_soft

   task automatic t_sources();
      for (int s = 0; s < 4; s++) begin
         wr(CTL, 8'h00);
         wr(SRC, {s[1:0], 6'h0f});
         wr(EN, 8'h80);
         wr(CTL, 8'h90);
         trig <= ~(4'h1 << s);
         settle();
         rc("other source", CTL, 8'h90);
         trig <= 4'hf;
         settle();
         rc("selected source", CTL, 8'h91);
         chk("source oe", {4'h0, oe}, 8'h00);
         trig <= 4'h0;
         settle();
         wr(CTL, 8'h94);
         rc("source release", CTL, 8'h90);
      end
   endtask : t_sources

   task automatic t_edges();
      wr(CTL, 8'h00);
      wr(SRC, 8'h0f);
      wr(EN, 8'h00);
      wr(CTL, 8'h90);
      trig <= 4'h1;
      settle();
      rc("gate closed", CTL, 8'h90);
      wr(EN, 8'h80);
      wr(CTL, 8'h00);
      wr(CTL, 8'h90);
      settle();
      rc("level at enable", CTL, 8'h90);
      wr(CTL, 8'h00);
      wr(CTL, 8'ha0);
      trig <= 4'h0;
      settle();
      rc("falling edge", CTL, 8'ha1);
      for (int k = 0; k < 2; k++) begin
         wr(CTL, 8'h00);
         wr(CTL, k == 0 ? 8'h80 : 8'hb0);
         trig <= 4'h1;
         settle();
         trig <= 4'h0;
         settle();
         rc("no edge field", CTL, k == 0 ? 8'h80 : 8'hb0);
      end
   endtask : t_edges

   task automatic t_policy();
      wr(CTL, 8'h00);
      wr(MSK, 8'h01);
      apb(1'b0, STA, 8'h00);
      wr(CTL, 8'hd0);
      trig <= 4'h1;
      settle();
      chk("hw irq", {7'h00, irq}, 8'h01);
      rc("hw status", STA, 8'h01);
      // only one command bit per write, never both
      wr(CTL, 8'hd4);
      rc("release held", CTL, 8'hd1);
      trig <= 4'h0;
      settle();
      wr(CTL, 8'hd4);
      rc("release ok", CTL, 8'hd0);
      chk("policy oe", {4'h0, oe}, 8'h0f);
   endtask : t_policy

   // the edge reaches the shutdown logic four edges after trig moves:
   // model, two sync flops, compare; the write's access edge is aimed there
   task automatic t_coincide();
      wr(CTL, 8'h00);
      wr(CTL, 8'h90);
      apb(1'b0, STA, 8'h00);
      trig <= 4'h1;
      repeat (2) @(posedge clk);
      wr(CTL, 8'h98);
      rc("soft on edge", STA, 8'h01);
      rc("edge flag", CTL, 8'h91);
      trig <= 4'h0;
      settle();
      wr(CTL, 8'h94);
      rc("release event", STA, 8'h04);
      wr(CTL, 8'h00);
      wr(CTL, 8'hd0);
      trig <= 4'h1;
      repeat (2) @(posedge clk);
      wr(CTL, 8'hd4);
      rc("release on edge", CTL, 8'hd1);
   endtask : t_coincide

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_soft();
      t_sources();
      t_edges();
      t_policy();
      t_coincide();
      finish_test();
   end
endmodule : pwm_hiz_output_shutdown_test

// ### tb/pwmhz_far_model.sv
// far side of the shutdown block: trigger sources and timer pwm levels
// assumes the bench commands trigger levels; the pwm pattern runs free
`timescale 1ns/1ps
module pwmhz_far_model (
   input wire logic i_clk,
   input wire logic [3:0] i_trig,
   output logic o_ext,
   output logic o_cmp0,
   output logic o_cmp1,
   output logic o_cmp2,
   output logic [3:0] o_timer
);
   logic [3:0] trig_r = 4'h0;
   logic [3:0] cnt_r = 4'h0;
   // triggers move only on command, so every edge seen is one the bench meant
   always_ff @(posedge i_clk) begin
      trig_r <= i_trig;
      cnt_r <= cnt_r + 4'h1;
   end
   assign {o_cmp2, o_cmp1, o_cmp0, o_ext} = trig_r;
   // pattern changes every cycle so a stuck pin path cannot pass
   assign o_timer = cnt_r;
endmodule : pwmhz_far_model
